// ===== crp_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module crp_bus_model
  import crp_pkg::*;
(
  // clock
  input wire logic core_clk,
  // frame path from the publisher
  input wire crp_frame_s tx_frame,
  input wire logic tx_valid,
  output logic tx_ready,
  // bus held by higher-priority nodes
  input wire logic stall
);
  crp_frame_s q[$];
  // frames that won arbitration, in bus order
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) begin
      q.push_back(tx_frame);
    end
    tx_ready <= !stall;
  end
endmodule // crp_bus_model
`default_nettype wire

// ===== crp_consts.svh
`ifndef CRP_CONSTS_SVH
`define CRP_CONSTS_SVH

// core clock rate, kHz (10 MHz)
`define CRP_CLK_KHZ 10000

// deadlines and update period, ms
`define CRP_START_MS 25
`define CRP_CANCEL_MS 100
`define CRP_MSG_MS 100
`define CRP_UPDATE_MS 100

// slot layout: reserved channels first, then user results
`define CRP_N_RSV 3
`define CRP_N_USER 16
`define CRP_RSV_STATE 0
`define CRP_RSV_TIME 1
`define CRP_RSV_LAT 2

// frame geometry, bytes
`define CRP_CLS_BYTES 7'h08
`define CRP_FD_BYTES 7'h40
`define CRP_VAL_BYTES 7'h04
`define CRP_CLS_DLC 4'h8

// ieee-754 single precision constants
`define CRP_FLOAT_ONE 32'h3F80_0000
`define CRP_FLOAT_ZERO 32'h0000_0000

`endif

// ===== crp_pkg.sv
`include "crp_consts.svh"

package crp_pkg;

  // one result slot: where its value goes on the bus
  typedef struct packed {
    logic en;
    logic [10:0] id;
    logic [5:0] pos;
  } crp_slot_s;

  // one base-format frame handed to the controller
  typedef struct packed {
    logic [10:0] id;
    logic fd;
    logic [3:0] dlc;
    logic [511:0] data;
  } crp_frame_s;

  typedef enum logic [2:0] {
    CRP_IDLE,
    CRP_PICK,
    CRP_GATHER,
    CRP_PUSH,
    CRP_DRAIN
  } crp_state_e;

endpackage

// ===== crp_result_publisher.sv
`timescale 1ns/100ps
`default_nettype none
`include "crp_consts.svh"

// What this block does
// - only base frames with 11-bit identifiers leave; never extended ones.
// - a mode input selects classic CAN 2.0 or flexible-data-rate framing.
// - every result goes out as a 32-bit float taking four data bytes.
// - classic frames carry one or two results, FD frames up to sixteen.
// - results sharing an identifier merge into one message at their ranges.
// - all messages of an update form one packet, pushed out to completion.
// - packets follow the update tick; values share one snapshot timestamp.
// - sending must start within 25 ms of snapshot completion, else skip.
// - an initiated packet still unfinished after 100 ms is cancelled.
// - pending data goes as soon as bus frees; late packets are skipped.
// - continuous overload lowers packet rate to what the bus sustains.
// - each message is retried for 100 ms, then dropped.
// - reserved acquisition-state channel is 1.0 when acquiring, else 0.0.
// - reserved channels carry acquisition time and latency in seconds.
// - nothing is transmitted while listen-only is on.
// - byte ranges must fit 8 bytes classic or 64 bytes FD.
module crp_result_publisher
  import crp_pkg::*;
#(
  parameter int N_SLOT = `CRP_N_RSV + `CRP_N_USER,
  parameter int UPD_CYC = `CRP_UPDATE_MS * `CRP_CLK_KHZ,
  parameter int START_CYC = `CRP_START_MS * `CRP_CLK_KHZ,
  parameter int CANCEL_CYC = `CRP_CANCEL_MS * `CRP_CLK_KHZ,
  parameter int MSG_CYC = `CRP_MSG_MS * `CRP_CLK_KHZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // configuration
  input wire logic fd_mode,
  input wire logic listen_only,
  input wire logic cfg_we,
  input wire logic [$clog2(N_SLOT)-1:0] cfg_idx,
  input wire crp_slot_s cfg_slot,
  // result values from the formula engine
  input wire logic res_we,
  input wire logic [$clog2(N_SLOT)-1:0] res_idx,
  input wire logic [31:0] res_val,
  input wire logic calc_done,
  // reserved channel sources
  input wire logic acq_active,
  input wire logic [31:0] acq_time,
  input wire logic [31:0] acq_latency,
  // update timing
  output logic snap_tick,
  // frame path to the controller
  output crp_frame_s tx_frame,
  output logic tx_valid,
  input wire logic tx_ready,
  // status
  output logic busy,
  output logic pkt_done,
  output logic pkt_skip,
  output logic pkt_cancel,
  output logic msg_drop
);

  localparam int IW = $clog2(N_SLOT);

  // byte range must be word aligned and inside the data field
  function automatic logic pos_ok(input logic [5:0] pos, input logic fd);
    logic [6:0] last;
    last = {1'b0, pos} + `CRP_VAL_BYTES;
    pos_ok = (pos[1:0] == 2'h0) &&
             (last <= (fd ? `CRP_FD_BYTES : `CRP_CLS_BYTES));
  endfunction

  // shortest FD length code that covers len bytes
  function automatic logic [3:0] dlc_of(input logic [6:0] len);
    if (len <= 7'h08) begin
      dlc_of = len[3:0];
    end else if (len <= 7'h0C) begin
      dlc_of = 4'h9;
    end else if (len <= 7'h10) begin
      dlc_of = 4'hA;
    end else if (len <= 7'h14) begin
      dlc_of = 4'hB;
    end else if (len <= 7'h18) begin
      dlc_of = 4'hC;
    end else if (len <= 7'h20) begin
      dlc_of = 4'hD;
    end else if (len <= 7'h30) begin
      dlc_of = 4'hE;
    end else begin
      dlc_of = 4'hF;
    end
  endfunction

  crp_slot_s cfg_ff [N_SLOT];
  logic [31:0] res_ff [N_SLOT];
  logic [31:0] snap_ff [N_SLOT];
  logic [31:0] upd_cnt_ff;
  logic snap_tick_ff;
  crp_state_e st_ff;
  logic [IW-1:0] idx_ff;
  logic [N_SLOT-1:0] sent_ff;
  logic [10:0] cur_id_ff;
  logic [511:0] data_ff;
  logic [6:0] len_ff;
  logic pkt_fd_ff;
  logic started_ff;
  logic [31:0] start_cnt_ff;
  logic [31:0] pkt_cnt_ff;
  logic [31:0] msg_cnt_ff;
  crp_frame_s head_ff;
  crp_frame_s tail_ff;
  logic head_vld_ff;
  logic tail_vld_ff;
  logic busy_ff;
  logic pkt_done_ff;
  logic pkt_skip_ff;
  logic pkt_cancel_ff;
  logic msg_drop_ff;

  logic last_idx;
  logic take;
  logic start_miss;
  logic pkt_to;
  logic abort;
  logic drop;
  logic push;
  logic pop;
  logic buf_empty;
  logic [6:0] slot_end;
  crp_slot_s cur_slot;
  crp_frame_s new_frm;

  assign last_idx = (idx_ff == IW'(N_SLOT - 1));
  assign cur_slot = cfg_ff[idx_ff];
  assign slot_end = {1'b0, cur_slot.pos} + `CRP_VAL_BYTES;
  assign buf_empty = !head_vld_ff && !tail_vld_ff;
  // a new snapshot is only taken between packets; otherwise it is skipped
  assign take = calc_done && (st_ff == CRP_IDLE) &&
                !listen_only;
  assign start_miss = (st_ff != CRP_IDLE) && !started_ff &&
                      (start_cnt_ff == 32'(START_CYC - 1));
  assign pkt_to = (st_ff != CRP_IDLE) && started_ff &&
                  (pkt_cnt_ff == 32'(CANCEL_CYC - 1));
  assign abort = start_miss || pkt_to ||
                 ((st_ff != CRP_IDLE) && listen_only);
  assign drop = head_vld_ff && !tx_ready &&
                (msg_cnt_ff == 32'(MSG_CYC - 1));
  assign push = (st_ff == CRP_PUSH) && !tail_vld_ff && !abort;
  assign pop = head_vld_ff && (tx_ready || drop);

  // frame carries only an 11-bit identifier field: no extended format
  always_comb begin
    new_frm.id = cur_id_ff;
    new_frm.fd = pkt_fd_ff;
    new_frm.dlc = pkt_fd_ff ? dlc_of(len_ff) : `CRP_CLS_DLC;
    new_frm.data = data_ff;
  end

  // update tick on multiples of the update period
  always_ff @(posedge core_clk) begin
    if (srst) begin
      upd_cnt_ff <= 32'h0000_0000;
      snap_tick_ff <= 1'b0;
    end else if (upd_cnt_ff == 32'(UPD_CYC - 1)) begin
      upd_cnt_ff <= 32'h0000_0000;
      snap_tick_ff <= 1'b1;
    end else begin
      upd_cnt_ff <= upd_cnt_ff + 32'h0000_0001;
      snap_tick_ff <= 1'b0;
    end
  end

  // slot configuration table
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < N_SLOT; i++) begin
        cfg_ff[i] <= '0;
      end
    end else if (cfg_we) begin
      cfg_ff[cfg_idx] <= cfg_slot;
    end
  end

  // live result values
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < N_SLOT; i++) begin
        res_ff[i] <= `CRP_FLOAT_ZERO;
      end
    end else if (res_we) begin
      res_ff[res_idx] <= res_val;
    end
  end

  // snapshot: every value of one packet frozen at the same instant
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < N_SLOT; i++) begin
        snap_ff[i] <= `CRP_FLOAT_ZERO;
      end
    end else if (take) begin
      for (int i = 0; i < N_SLOT; i++) begin
        snap_ff[i] <= res_ff[i];
      end
      snap_ff[`CRP_RSV_STATE] <= acq_active ?
                                 `CRP_FLOAT_ONE : `CRP_FLOAT_ZERO;
      snap_ff[`CRP_RSV_TIME] <= acq_time;
      snap_ff[`CRP_RSV_LAT] <= acq_latency;
    end
  end

  // packet builder: one message per distinct identifier, in slot order
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff <= CRP_IDLE;
      idx_ff <= '0;
      sent_ff <= '0;
      cur_id_ff <= 11'h000;
      data_ff <= '0;
      len_ff <= 7'h00;
      pkt_fd_ff <= 1'b0;
      started_ff <= 1'b0;
    end else if (abort) begin
      st_ff <= CRP_IDLE;
      started_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        CRP_IDLE: begin
          if (take) begin
            st_ff <= CRP_PICK;
            idx_ff <= '0;
            sent_ff <= '0;
            pkt_fd_ff <= fd_mode;
            started_ff <= 1'b0;
          end
        end
        CRP_PICK: begin
          if (cur_slot.en && !sent_ff[idx_ff] &&
              pos_ok(cur_slot.pos, pkt_fd_ff)) begin
            cur_id_ff <= cur_slot.id;
            data_ff <= '0;
            len_ff <= 7'h00;
            idx_ff <= '0;
            st_ff <= CRP_GATHER;
          end else if (last_idx) begin
            st_ff <= CRP_DRAIN;
          end else begin
            idx_ff <= idx_ff + IW'(1);
          end
        end
        CRP_GATHER: begin
          if (cur_slot.en && !sent_ff[idx_ff] &&
              (cur_slot.id == cur_id_ff) &&
              pos_ok(cur_slot.pos, pkt_fd_ff)) begin
            data_ff[{cur_slot.pos, 3'h0} +: 32] <= snap_ff[idx_ff];
            sent_ff[idx_ff] <= 1'b1;
            if (slot_end > len_ff) begin
              len_ff <= slot_end;
            end
          end
          if (last_idx) begin
            st_ff <= CRP_PUSH;
          end else begin
            idx_ff <= idx_ff + IW'(1);
          end
        end
        CRP_PUSH: begin
          if (push) begin
            started_ff <= 1'b1;
            idx_ff <= '0;
            st_ff <= CRP_PICK;
          end
        end
        CRP_DRAIN: begin
          if (buf_empty) begin
            st_ff <= CRP_IDLE;
          end
        end
      endcase
    end
  end

  // deadline counters
  always_ff @(posedge core_clk) begin
    if (srst || (st_ff == CRP_IDLE) || started_ff) begin
      start_cnt_ff <= 32'h0000_0000;
    end else begin
      start_cnt_ff <= start_cnt_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || (st_ff == CRP_IDLE) || !started_ff) begin
      pkt_cnt_ff <= 32'h0000_0000;
    end else begin
      pkt_cnt_ff <= pkt_cnt_ff + 32'h0000_0001;
    end
  end

  // per-message retry time while the controller does not take the head
  always_ff @(posedge core_clk) begin
    if (srst || !head_vld_ff || pop || abort) begin
      msg_cnt_ff <= 32'h0000_0000;
    end else begin
      msg_cnt_ff <= msg_cnt_ff + 32'h0000_0001;
    end
  end

  // two-entry frame buffer; head drives the controller port directly
  always_ff @(posedge core_clk) begin
    if (srst || abort) begin
      head_vld_ff <= 1'b0;
      tail_vld_ff <= 1'b0;
      if (srst) begin
        head_ff <= '0;
        tail_ff <= '0;
      end
    end else if (pop) begin
      if (tail_vld_ff) begin
        head_ff <= tail_ff;
        tail_vld_ff <= 1'b0;
      end else begin
        head_vld_ff <= push;
        if (push) begin
          head_ff <= new_frm;
        end
      end
    end else if (push) begin
      if (!head_vld_ff) begin
        head_ff <= new_frm;
        head_vld_ff <= 1'b1;
      end else begin
        tail_ff <= new_frm;
        tail_vld_ff <= 1'b1;
      end
    end
  end

  // status: busy level and event pulses
  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy_ff <= 1'b0;
      pkt_done_ff <= 1'b0;
      pkt_skip_ff <= 1'b0;
      pkt_cancel_ff <= 1'b0;
      msg_drop_ff <= 1'b0;
    end else begin
      busy_ff <= (st_ff != CRP_IDLE);
      pkt_done_ff <= (st_ff == CRP_DRAIN) && buf_empty && !abort;
      pkt_skip_ff <= (calc_done && !take) || start_miss;
      pkt_cancel_ff <= pkt_to || ((st_ff != CRP_IDLE) && listen_only);
      msg_drop_ff <= drop;
    end
  end

  assign snap_tick = snap_tick_ff;
  assign tx_frame = head_ff;
  assign tx_valid = head_vld_ff;
  assign busy = busy_ff;
  assign pkt_done = pkt_done_ff;
  assign pkt_skip = pkt_skip_ff;
  assign pkt_cancel = pkt_cancel_ff;
  assign msg_drop = msg_drop_ff;

endmodule // crp_result_publisher

`default_nettype wire

// ===== crp_result_publisher_chk.sv
`timescale 1ns/100ps
`default_nettype none
module crp_result_publisher_chk
  import crp_pkg::*;
#(
  parameter int UPD_CYC = 200,
  parameter int START_CYC = 150,
  parameter int CANCEL_CYC = 400,
  parameter int MSG_CYC = 50
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // inputs
  input wire logic listen_only,
  input wire logic calc_done,
  input wire logic tx_ready,
  // outputs
  input wire logic snap_tick,
  input wire crp_frame_s tx_frame,
  input wire logic tx_valid,
  input wire logic busy,
  input wire logic pkt_done,
  input wire logic pkt_skip,
  input wire logic pkt_cancel,
  input wire logic msg_drop
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  int tcnt;
  int hcnt;
  int bcnt;
  always_ff @(posedge core_clk) begin
    tcnt <= (srst || snap_tick) ? 0 : tcnt + 1;
  end
  // length of the current stall of the head frame
  always_ff @(posedge core_clk) begin
    hcnt <= (srst || !tx_valid || tx_ready || msg_drop) ? 0 : hcnt + 1;
  end
  always_ff @(posedge core_clk) begin
    bcnt <= (srst || !busy) ? 0 : bcnt + 1;
  end
  a_classic_dlc: assert property (
    tx_valid && !tx_frame.fd |-> tx_frame.dlc == 4'h8)
    else $error("classic frame length wrong");
  a_fd_dlc_min: assert property (
    tx_valid && tx_frame.fd |-> tx_frame.dlc >= 4'h4)
    else $error("fd frame too short for a value");
  a_listen_quiet: assert property (
    listen_only [*3] |-> !tx_valid)
    else $error("frame offered in listen-only");
  a_head_holds: assert property (
    tx_valid && !tx_ready |=> (tx_valid && $stable(tx_frame))
    or (##[0:1] (msg_drop || pkt_cancel)))
    else $error("head frame lost without drop");
  a_drop_bound: assert property (hcnt <= MSG_CYC + 2)
    else $error("stalled frame not dropped in time");
  a_refuse_skip: assert property (
    calc_done && (tx_valid || listen_only) |=> ##[0:1] pkt_skip)
    else $error("refused snapshot not reported");
  a_busy_bound: assert property (
    bcnt <= START_CYC + CANCEL_CYC + 64)
    else $error("packet outlived its deadlines");
  a_tick_period: assert property (
    snap_tick |-> tcnt >= UPD_CYC - 2 && tcnt <= UPD_CYC)
    else $error("update tick off period");
  a_tick_due: assert property (tcnt <= UPD_CYC)
    else $error("update tick missing");
  a_done_alone: assert property (
    pkt_done |-> !pkt_cancel)
    else $error("packet both done and cancelled");
endmodule // crp_result_publisher_chk
bind crp_result_publisher crp_result_publisher_chk #(.UPD_CYC(UPD_CYC),
  .START_CYC(START_CYC), .CANCEL_CYC(CANCEL_CYC), .MSG_CYC(MSG_CYC))
  chk_u (.core_clk, .srst, .listen_only, .calc_done, .tx_ready, .snap_tick,
  .tx_frame, .tx_valid, .busy, .pkt_done, .pkt_skip, .pkt_cancel, .msg_drop);
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
  import crp_pkg::*;
;
  typedef struct packed {
    logic fd;
    logic [10:0] id;
    logic [5:0] pos;
    logic [31:0] v;
    logic [3:0] dlc;
  } crp_row_s;
  logic core_clk = 1'h0, srst = 1'h1, fd_mode = 1'h0, listen_only = 1'h0;
  logic cfg_we = 1'h0, res_we = 1'h0, calc_done = 1'h0, acq_active = 1'h0;
  logic stall = 1'h0;
  logic [4:0] cfg_idx = 5'h00, res_idx = 5'h00;
  crp_slot_s cfg_slot = '0;
  logic [31:0] res_val = 32'h0, acq_time = 32'h0, acq_latency = 32'h0;
  logic snap_tick, tx_valid, tx_ready, busy;
  logic pkt_done, pkt_skip, pkt_cancel, msg_drop;
  crp_frame_s tx_frame, f;
  int err_count = 0, n_compared = 0, cyc = 0, d, s, s3;
  int ev[4] = '{default: 0};
  crp_row_s rows[5] = '{
    '{1'h0, 11'h7FF, 6'h00, 32'h3F80_0000, 4'h8},
    '{1'h0, 11'h000, 6'h04, 32'hC120_0000, 4'h8},
    '{1'h1, 11'h123, 6'h00, 32'h4049_0FDB, 4'h4},
    '{1'h1, 11'h456, 6'h08, 32'h1234_5678, 4'h9},
    '{1'h1, 11'h3A5, 6'h3C, 32'hDEAD_BEEF, 4'hF}};
  crp_result_publisher #(.UPD_CYC(2000), .START_CYC(30), .CANCEL_CYC(400),
    .MSG_CYC(300)) dut_u (.core_clk, .srst, .fd_mode, .listen_only, .cfg_we,
    .cfg_idx, .cfg_slot, .res_we, .res_idx, .res_val, .calc_done,
    .acq_active, .acq_time, .acq_latency, .snap_tick, .tx_frame, .tx_valid,
    .tx_ready, .busy, .pkt_done, .pkt_skip, .pkt_cancel, .msg_drop);
  crp_bus_model bus_u (.core_clk, .tx_frame, .tx_valid, .tx_ready, .stall);
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    ev <= '{ev[0] + pkt_done, ev[1] + pkt_skip, ev[2] + pkt_cancel,
      ev[3] + msg_drop};
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input int i, input logic [10:0] id, input logic [5:0] p);
    @(posedge core_clk);
    cfg_we <= 1'h1;
    cfg_idx <= 5'(i);
    cfg_slot <= '{1'h1, id, p};
    @(posedge core_clk);
    cfg_we <= 1'h0;
  endtask
  task automatic val(input int i, input logic [31:0] v);
    @(posedge core_clk);
    res_we <= 1'h1;
    res_idx <= 5'(i);
    res_val <= v;
    @(posedge core_clk);
    res_we <= 1'h0;
  endtask
  task automatic pulse();
    @(posedge core_clk);
    calc_done <= 1'h1;
    @(posedge core_clk);
    calc_done <= 1'h0;
  endtask
  task automatic snap();
    for (int n = 0; busy !== 1'h0 && n < 3000; n++) @(posedge core_clk);
    pulse();
  endtask
  task automatic frame();
    for (int n = 0; bus_u.q.size() == 0 && n < 3000; n++) @(posedge core_clk);
    f = bus_u.q.size() ? bus_u.q.pop_front() : '0;
  endtask
  // wait for counter k to move past s; d is how far it moved
  task automatic wait_ev(input int k);
    for (int n = 0; ev[k] == s && n < 1500; n++) @(posedge core_clk);
    d = ev[k] - s;
  endtask
  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'h0;
    @(posedge core_clk);
    chk({tx_valid, busy, pkt_done, pkt_skip, msg_drop}, 0);
    foreach (rows[i]) begin
      fd_mode <= rows[i].fd;
      cfg(3, rows[i].id, rows[i].pos);
      val(3, rows[i].v);
      s = ev[0];
      snap();
      frame();
      chk(f.id, rows[i].id);
      chk(f.fd, rows[i].fd);
      chk(f.dlc, rows[i].dlc);
      chk(f.data[rows[i].pos*8 +: 32], rows[i].v);
      wait_ev(0);
      chk(d, 1);
    end
    // misaligned slot 3 is ignored; slot 18 alone cannot start in time
    cfg(3, 11'h3A5, 6'h06);
    cfg(18, 11'h2AA, 6'h00);
    s = ev[1];
    snap();
    wait_ev(1);
    chk(d, 1);
    chk(bus_u.q.size(), 0);
    cfg(18, 11'h2AA, 6'h06);
    fd_mode <= 1'h0;
    acq_active <= 1'h1;
    acq_time <= 32'h4120_0000;
    acq_latency <= 32'h3C23_D70A;
    cfg(0, 11'h100, 6'h00);
    cfg(1, 11'h100, 6'h04);
    cfg(2, 11'h101, 6'h00);
    cfg(3, 11'h101, 6'h04);
    cfg(4, 11'h101, 6'h08);
    val(0, 32'h5555_5555);
    val(3, 32'h4000_0000);
    val(4, 32'hFFFF_FFFF);
    snap();
    frame();
    chk(f.id, 11'h100);
    chk(f.data[31:0], 32'h3F80_0000);
    chk(f.data[63:32], 32'h4120_0000);
    frame();
    chk(f.id, 11'h101);
    chk(f.data[31:0], 32'h3C23_D70A);
    chk(f.data[63:32], 32'h4000_0000);
    acq_active <= 1'h0;
    s = ev[1];
    snap();
    pulse();
    wait_ev(1);
    chk(d, 1);
    frame();
    chk(f.data[31:0], 32'h0);
    frame();
    stall <= 1'h1;
    s = ev[2];
    s3 = ev[3];
    snap();
    wait_ev(2);
    chk(d, 1);
    chk(ev[3] - s3, 1);
    stall <= 1'h0;
    chk(bus_u.q.size(), 0);
    snap();
    frame();
    chk(f.id, 11'h100);
    frame();
    chk(f.id, 11'h101);
    listen_only <= 1'h1;
    s = ev[1];
    snap();
    wait_ev(1);
    chk(d, 1);
    listen_only <= 1'h0;
    stall <= 1'h1;
    s = ev[2];
    snap();
    repeat (60) @(posedge core_clk);
    listen_only <= 1'h1;
    wait_ev(2);
    chk(d, 1);
    stall <= 1'h0;
    repeat (50) @(posedge core_clk);
    chk(bus_u.q.size(), 0);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
